/* File: serial_display_defs.svh */
// Constants of the serial display packet layer.
//
// Contract
// - Multi-byte fields travel low byte first.
// - Every packet header is four bytes.
// - Short header: identifier, two data bytes, code.
// - Long header: identifier, length word, code.
// - Identifier: channel bits 7-6, type 5-0.
// - Replies use channel zero like host.
// - Only channel zero is accepted here.
// - Types 05h, 15h write; 06h reads.
// - Type 39h is long command write.
// - Type 37h sets maximum return size.
// - Type 08h is short end packet.
// - Types 09h, 19h are empty long packets.
// - Sync types 01h, 11h, 21h, 31h short.
// - Generic writes behave like command writes.
// - Generic read 14h acts as command read.
// - Pixel types 0Eh-3Eh are long packets.
// - Unknown types drop the rest of the burst.
// - Error reply 02h, long read reply 1Ch.
// - Short read replies 21h one, 22h two.
// - Generic reply types ignored while disabled.
// - One-byte short payload pads zero second byte.
// - Bits within a byte travel LSB first.
// - Header good only when syndrome is zero.
`ifndef SERIAL_DISPLAY_DEFS_SVH
`define SERIAL_DISPLAY_DEFS_SVH
`define HDR_BYTES        3'h4
`define CHAN_OWN         2'h0
`define SYND_OK          8'h00
`define TYPE_END_XFER    6'h08
`define TYPE_WRITE0      6'h05
`define TYPE_WRITE1      6'h15
`define TYPE_READ0       6'h06
`define TYPE_MAX_RET     6'h37
`define TYPE_NULL        6'h09
`define TYPE_BLANK       6'h19
`define TYPE_LONG_WRITE  6'h39
`define TYPE_VS_START    6'h01
`define TYPE_VS_END      6'h11
`define TYPE_HS_START    6'h21
`define TYPE_HS_END      6'h31
`define TYPE_CM_OFF      6'h02
`define TYPE_CM_ON       6'h12
`define TYPE_SHUT_DOWN   6'h22
`define TYPE_TURN_ON     6'h32
`define TYPE_GEN_WRITE1  6'h13
`define TYPE_GEN_WRITE2  6'h23
`define TYPE_GEN_LWRITE  6'h29
`define TYPE_GEN_READ1   6'h14
`define TYPE_PIX16       6'h0e
`define TYPE_PIX18       6'h1e
`define TYPE_PIX18_LOOSE 6'h2e
`define TYPE_PIX24       6'h3e
`define TYPE_ACK_ERR     6'h02
`define TYPE_RD_LONG     6'h1c
`define TYPE_RD_ONE      6'h21
`define TYPE_RD_TWO      6'h22
`define TYPE_GRD_LONG    6'h1a
`define TYPE_GRD_ONE     6'h11
`define TYPE_GRD_TWO     6'h12
`define CODE_MASK_P0     24'hf12cb7
`define CODE_MASK_P1     24'hf2555b
`define CODE_MASK_P2     24'h749a6d
`define CODE_MASK_P3     24'hb8e38e
`define CODE_MASK_P4     24'hdf03f0
`define CODE_MASK_P5     24'heffc00
`endif

/* File: pkt_types_pkg.sv */
// Types shared by the serial display packet layer.
package pkt_types_pkg;
  typedef enum logic [1:0] {st_hdr, st_pay, st_drop} frame_state_e;
  typedef enum logic [3:0] {
    cls_none, cls_end_xfer, cls_write, cls_read, cls_max_size,
    cls_null, cls_long_write, cls_sync, cls_pixel, cls_periph
  } pkt_class_e;
  typedef enum logic [1:0] {rk_ack_error, rk_one, rk_two, rk_long} reply_kind_e;
endpackage

/* File: serial_display_packet_layer.sv */
// Packet header receiver and reply header builder of the serial display link.
`timescale 1ns/1ps
`include "serial_display_defs.svh"
module serial_display_packet_layer (
  // Clock, reset and clock enable.
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // Link pins, asynchronous to ref_clk.
  input  wire logic                        link_clk,
  input  wire logic                        link_data,
  input  wire logic                        link_active,
  // Configuration.
  input  wire logic                        generic_packet_enable,
  // Received header.
  output logic                             hdr_valid,
  output logic                             hdr_error,
  output logic [5:0]                       hdr_type,
  output pkt_types_pkg::pkt_class_e        hdr_class,
  output logic [15:0]                      short_payload,
  output logic [15:0]                      payload_length,
  output logic [15:0]                      max_return_size,
  // Long packet payload.
  output logic [7:0]                       pay_byte,
  output logic                             pay_valid,
  output logic                             pkt_done,
  // Reply request.
  input  wire logic                        rsp_req,
  input  pkt_types_pkg::reply_kind_e       rsp_kind,
  input  wire logic                        rsp_generic,
  input  wire logic [15:0]                 rsp_data,
  // Reply header.
  output logic                             rsp_valid,
  output logic [31:0]                      rsp_header
);

  // ***************************************************************
  // Functions
  // ***************************************************************

  // Six-bit header code over the 24 header bits, top two bits zero.
  function automatic logic [7:0] err_code(input logic [23:0] d);
    begin
      err_code = {2'b00, ^(d & `CODE_MASK_P5), ^(d & `CODE_MASK_P4),
                  ^(d & `CODE_MASK_P3), ^(d & `CODE_MASK_P2),
                  ^(d & `CODE_MASK_P1), ^(d & `CODE_MASK_P0)};
    end
  endfunction

  // Maps a received type to its class; generic writes fold into writes.
  function automatic pkt_types_pkg::pkt_class_e classify(
    input logic [5:0] t,
    input logic       gen_en
  );
    begin
      case (t)
        `TYPE_END_XFER: classify = pkt_types_pkg::cls_end_xfer;
        `TYPE_WRITE0, `TYPE_WRITE1,
        `TYPE_GEN_WRITE1, `TYPE_GEN_WRITE2:
          classify = pkt_types_pkg::cls_write;
        `TYPE_READ0, `TYPE_GEN_READ1:
          classify = pkt_types_pkg::cls_read;
        `TYPE_MAX_RET: classify = pkt_types_pkg::cls_max_size;
        `TYPE_NULL, `TYPE_BLANK: classify = pkt_types_pkg::cls_null;
        `TYPE_LONG_WRITE, `TYPE_GEN_LWRITE:
          classify = pkt_types_pkg::cls_long_write;
        `TYPE_VS_START, `TYPE_VS_END, `TYPE_HS_START, `TYPE_HS_END:
          classify = pkt_types_pkg::cls_sync;
        `TYPE_PIX16, `TYPE_PIX18, `TYPE_PIX18_LOOSE, `TYPE_PIX24:
          classify = pkt_types_pkg::cls_pixel;
        `TYPE_CM_OFF, `TYPE_CM_ON, `TYPE_SHUT_DOWN, `TYPE_TURN_ON:
          classify = pkt_types_pkg::cls_periph;
        default: classify = pkt_types_pkg::cls_none;
      endcase
      // Codes shared with generic replies vanish while generic is off.
      if (!gen_en && (t == `TYPE_GRD_ONE || t == `TYPE_GRD_TWO ||
                      t == `TYPE_GRD_LONG)) begin
        classify = pkt_types_pkg::cls_none;
      end
    end
  endfunction

  // Classes whose header carries a length word instead of data.
  function automatic logic is_long(input pkt_types_pkg::pkt_class_e c);
    begin
      is_long = (c == pkt_types_pkg::cls_null) ||
                (c == pkt_types_pkg::cls_long_write) ||
                (c == pkt_types_pkg::cls_pixel);
    end
  endfunction

  // Type code of an outgoing reply.
  function automatic logic [5:0] reply_type(
    input pkt_types_pkg::reply_kind_e k,
    input logic                       gen
  );
    begin
      case (k)
        pkt_types_pkg::rk_ack_error: reply_type = `TYPE_ACK_ERR;
        pkt_types_pkg::rk_one: reply_type = gen ? `TYPE_GRD_ONE : `TYPE_RD_ONE;
        pkt_types_pkg::rk_two: reply_type = gen ? `TYPE_GRD_TWO : `TYPE_RD_TWO;
        default: reply_type = gen ? `TYPE_GRD_LONG : `TYPE_RD_LONG;
      endcase
    end
  endfunction

  // ***************************************************************
  // Pin synchronisers and bit assembly
  // ***************************************************************

  logic [2:0]                  clk_sync_reg;
  logic [1:0]                  data_sync_reg;
  logic [1:0]                  act_sync_reg;
  logic [7:0]                  shift_reg;
  logic [2:0]                  bit_cnt_reg;
  logic                        byte_valid_reg;
  logic                        clk_rise;

  // Stage one of each chain feeds only stage two.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_sync_reg  <= 3'h0;
      data_sync_reg <= 2'h0;
      act_sync_reg  <= 2'h0;
    end else if (ce) begin
      clk_sync_reg  <= {clk_sync_reg[1:0], link_clk};
      data_sync_reg <= {data_sync_reg[0], link_data};
      act_sync_reg  <= {act_sync_reg[0], link_active};
    end
  end

  // Data and clock share the same delay, so data stays aligned.
  assign clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];

  // Shift bits in on each link clock rise; the first bit is the LSB.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 3'h0;
      byte_valid_reg <= 1'b0;
    end else if (ce) begin
      byte_valid_reg <= 1'b0;
      if (!act_sync_reg[1]) begin
        bit_cnt_reg <= 3'h0;
      end else if (clk_rise) begin
        shift_reg   <= {data_sync_reg[1], shift_reg[7:1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          byte_valid_reg <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // Header decode and payload framing
  // ***************************************************************

  pkt_types_pkg::frame_state_e state_reg;
  logic [1:0]                  hdr_cnt_reg;
  logic [23:0]                 hdr_buf_reg;
  logic [15:0]                 pay_left_reg;
  logic                        keep_reg;
  logic [15:0]                 pay_seen_reg;
  logic [7:0]                  syndrome;
  pkt_types_pkg::pkt_class_e   cls;
  logic                        chan_ok;
  logic [15:0]                 word;

  // The fourth byte in shift_reg is the received code.
  assign syndrome = err_code(hdr_buf_reg) ^ shift_reg;
  assign cls      = classify(hdr_buf_reg[5:0], generic_packet_enable);
  assign chan_ok  = (hdr_buf_reg[7:6] == `CHAN_OWN);
  assign word     = hdr_buf_reg[23:8];

  // A bad header leaves the length unknown, so the rest of the burst
  // is dropped until the link goes idle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg       <= pkt_types_pkg::st_hdr;
      hdr_cnt_reg     <= 2'h0;
      hdr_buf_reg     <= 24'h000000;
      pay_left_reg    <= 16'h0000;
      keep_reg        <= 1'b0;
      pay_seen_reg    <= 16'h0000;
      hdr_valid       <= 1'b0;
      hdr_error       <= 1'b0;
      hdr_type        <= 6'h00;
      hdr_class       <= pkt_types_pkg::cls_none;
      short_payload   <= 16'h0000;
      payload_length  <= 16'h0000;
      max_return_size <= 16'h0000;
      pay_byte        <= 8'h00;
      pay_valid       <= 1'b0;
      pkt_done        <= 1'b0;
    end else if (ce) begin
      hdr_valid <= 1'b0;
      hdr_error <= 1'b0;
      pay_valid <= 1'b0;
      pkt_done  <= 1'b0;
      if (!act_sync_reg[1]) begin
        state_reg   <= pkt_types_pkg::st_hdr;
        hdr_cnt_reg <= 2'h0;
      end else if (byte_valid_reg) begin
        case (state_reg)
          pkt_types_pkg::st_hdr: begin
            hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
            if (hdr_cnt_reg != 2'h3) begin
              hdr_buf_reg[{hdr_cnt_reg, 3'b000} +: 8] <= shift_reg;
            end else begin
              pay_seen_reg <= 16'h0000;
              if (syndrome != `SYND_OK) begin
                hdr_error <= 1'b1;
                state_reg <= pkt_types_pkg::st_drop;
              end else if (cls == pkt_types_pkg::cls_none) begin
                state_reg <= pkt_types_pkg::st_drop;
              end else if (is_long(cls)) begin
                keep_reg     <= chan_ok;
                pay_left_reg <= word;
                if (chan_ok) begin
                  hdr_valid      <= 1'b1;
                  hdr_type       <= hdr_buf_reg[5:0];
                  hdr_class      <= cls;
                  payload_length <= word;
                  pkt_done       <= (word == 16'h0000);
                end
                if (word != 16'h0000) begin
                  state_reg <= pkt_types_pkg::st_pay;
                end
              end else if (chan_ok) begin
                hdr_valid     <= 1'b1;
                hdr_type      <= hdr_buf_reg[5:0];
                hdr_class     <= cls;
                short_payload <= word;
                if (cls == pkt_types_pkg::cls_max_size) begin
                  max_return_size <= word;
                end
              end
            end
          end
          pkt_types_pkg::st_pay: begin
            pay_left_reg <= pay_left_reg - 16'h0001;
            pay_seen_reg <= pay_seen_reg + 16'h0001;
            pay_byte     <= shift_reg;
            // Null and blanking payloads carry nothing worth passing on.
            pay_valid    <= keep_reg && (hdr_class != pkt_types_pkg::cls_null);
            if (pay_left_reg == 16'h0001) begin
              pkt_done  <= keep_reg;
              state_reg <= pkt_types_pkg::st_hdr;
            end
          end
          pkt_types_pkg::st_drop: state_reg <= pkt_types_pkg::st_drop;
          default: state_reg <= pkt_types_pkg::st_hdr;
        endcase
      end
    end
  end

  // ***************************************************************
  // Reply header builder
  // ***************************************************************

  logic [23:0]                 rsp_body;

  // Channel zero always; a one-byte reply pads its second byte.
  assign rsp_body = {(rsp_kind == pkt_types_pkg::rk_one) ? 8'h00 : rsp_data[15:8],
                     rsp_data[7:0],
                     `CHAN_OWN,
                     reply_type(rsp_kind, rsp_generic && generic_packet_enable)};

  // Byte 0 sits in the low bits, so it is sent first.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid  <= 1'b0;
      rsp_header <= 32'h00000000;
    end else if (ce) begin
      rsp_valid <= rsp_req;
      if (rsp_req) begin
        rsp_header <= {err_code(rsp_body), rsp_body};
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking dflt_cb @(posedge ref_clk); endclocking
  default disable iff (rst || !ce);

  a_rsp_channel: assert property (rsp_valid |-> rsp_header[7:6] == 2'b00)
    else $error("reply sent on a nonzero channel");
  a_rsp_code: assert property (rsp_valid |->
      rsp_header[31:24] == err_code(rsp_header[23:0]))
    else $error("reply header code does not match its bytes");
  // A request held during reset is not taken, so reset cycles are left out.
  a_one_byte_pad: assert property (!$past(rst) && $past(ce) && $past(rsp_req) &&
      $past(rsp_kind) == pkt_types_pkg::rk_one |-> rsp_valid && rsp_header[23:16] == 8'h00)
    else $error("one-byte reply second byte not zero");
  a_ack_type: assert property (!$past(rst) && $past(ce) && $past(rsp_req) &&
      $past(rsp_kind) == pkt_types_pkg::rk_ack_error |-> rsp_valid && rsp_header[5:0] == 6'h02)
    else $error("error reply has wrong type");
  // The drop state is entered on the same edge that raises the error pulse.
  a_err_drops_burst: assert property (hdr_error |->
      !hdr_valid && state_reg == pkt_types_pkg::st_drop)
    else $error("bad header not dropped");
  a_unknown_dropped: assert property (hdr_valid |->
      hdr_class != pkt_types_pkg::cls_none)
    else $error("unknown type reported");
  a_generic_gate: assert property ($past(ce) && hdr_valid &&
      !$past(generic_packet_enable) |-> !(hdr_type inside {6'h11, 6'h12, 6'h1a}))
    else $error("generic reply type accepted while disabled");
  a_payload_count: assert property (pkt_done |-> pay_seen_reg == payload_length)
    else $error("payload byte count differs from length");
  a_generic_read: assert property (hdr_valid && hdr_type == 6'h14 |->
      hdr_class == pkt_types_pkg::cls_read)
    else $error("generic read not handled as read");

endmodule

/* File: host_link_model.sv */
// Host side model that serialises packet bytes onto the display link pins.
`timescale 1ns/1ps
module host_link_model (
  // Link pins toward the display.
  output logic link_clk,
  output logic link_data,
  output logic link_active
);
  // ************************************************************
  // Header code and burst sender
  // ************************************************************

  // Parity masks of the six code bits over the 24 header data bits.
  localparam logic [23:0] code_mask [6] = '{24'hf12cb7, 24'hf2555b, 24'h749a6d,
                                            24'hb8e38e, 24'hdf03f0, 24'heffc00};

  // Code byte of a header; the two top bits are always zero.
  function automatic logic [7:0] hdr_code(input logic [23:0] d);
    hdr_code = 8'h00;
    for (int p = 0; p < 6; p++) begin
      hdr_code[p] = ^(d & code_mask[p]);
    end
  endfunction

  // The link clock stands low between bursts, so nothing is sampled there.
  initial begin
    link_clk    = 1'b0;
    link_data   = 1'b0;
    link_active = 1'b0;
  end

  // Bytes leave in queue order; data moves on the falling clock edge.
  task automatic send_burst(input logic [7:0] b[$]);
    link_active = 1'b1;
    #80;
    for (int i = 0; i < b.size(); i++) begin
      for (int k = 0; k < 8; k++) begin
        link_data = b[i][k];
        #40 link_clk = 1'b1;
        #40 link_clk = 1'b0;
      end
    end
    // A released data line must not keep showing the last bit.
    link_data = ~link_data;
    #200 link_active = 1'b0;
    #400;
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench of the serial display packet layer.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top;
  logic                             ref_clk, rst, ce, gen_en;
  logic                             link_clk, link_data, link_active;
  logic                             hdr_valid, hdr_error, pay_valid, pkt_done;
  logic [5:0]                       hdr_type;
  pkt_types_pkg::pkt_class_e        hdr_class;
  logic [15:0]                      short_payload, payload_length, max_return_size;
  logic [7:0]                       pay_byte;
  logic                             rsp_req, rsp_generic, rsp_valid;
  pkt_types_pkg::reply_kind_e       rsp_kind;
  logic [15:0]                      rsp_data;
  logic [31:0]                      rsp_header;
  int                               n_mismatch, samples_checked, n_hdr, n_err, n_done;
  logic [7:0]                       pay_q[$];
  logic [7:0]                       burst[$];

  host_link_model host (.link_clk(link_clk), .link_data(link_data),
                        .link_active(link_active));

  serial_display_packet_layer dut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .link_clk(link_clk),
    .link_data(link_data), .link_active(link_active),
    .generic_packet_enable(gen_en), .hdr_valid(hdr_valid),
    .hdr_error(hdr_error), .hdr_type(hdr_type), .hdr_class(hdr_class),
    .short_payload(short_payload), .payload_length(payload_length),
    .max_return_size(max_return_size), .pay_byte(pay_byte),
    .pay_valid(pay_valid), .pkt_done(pkt_done), .rsp_req(rsp_req),
    .rsp_kind(rsp_kind), .rsp_generic(rsp_generic), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_header(rsp_header));

  // The 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // Pulses are counted here, so a burst can be judged after it has ended.
  always @(posedge ref_clk) begin
    if (hdr_valid === 1'b1) n_hdr++;
    if (hdr_error === 1'b1) n_err++;
    if (pkt_done === 1'b1) n_done++;
    if (pay_valid === 1'b1) pay_q.push_back(pay_byte);
  end

  // ************************************************************
  // Helpers
  // ************************************************************

  // Header as identifier, low word byte, high word byte, code.
  task automatic add_hdr(input logic [7:0] di, input logic [15:0] w, input logic [7:0] flip);
    burst.push_back(di);
    burst.push_back(w[7:0]);
    burst.push_back(w[15:8]);
    burst.push_back(host.hdr_code({w, di}) ^ flip);
  endtask

  // Sends the collected bytes as one burst with fresh counters.
  task automatic go();
    n_hdr = 0;
    n_err = 0;
    n_done = 0;
    pay_q.delete();
    host.send_burst(burst);
    burst.delete();
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************

  // Every host short type; classes are coded in the enum order of the package.
  task automatic t_short();
    logic [5:0] ty [16] = '{6'h05, 6'h15, 6'h06, 6'h37, 6'h08, 6'h01, 6'h11, 6'h21,
                           6'h31, 6'h02, 6'h12, 6'h22, 6'h32, 6'h13, 6'h23, 6'h14};
    logic [3:0] cl [16] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h1, 4'h7, 4'h7, 4'h7,
                           4'h7, 4'h9, 4'h9, 4'h9, 4'h9, 4'h2, 4'h2, 4'h3};
    for (int i = 0; i < 16; i++) begin
      add_hdr({2'b00, ty[i]}, {8'h00, 8'h40 + 8'(i)}, 8'h00);
      go();
      `CHECK("short count", 1, n_hdr)
      `CHECK("short type", ty[i], hdr_type)
      `CHECK("short class", cl[i], 4'(hdr_class))
      `CHECK("short data", {8'h00, 8'h40 + 8'(i)}, short_payload)
      if (ty[i] == 6'h37) `CHECK("max size", 16'h0043, max_return_size)
    end
    $display("short types done");
  endtask

  // Every host long type with one payload byte.
  task automatic t_long();
    logic [5:0] ty [8] = '{6'h39, 6'h29, 6'h09, 6'h19, 6'h0e, 6'h1e, 6'h2e, 6'h3e};
    logic [3:0] cl [8] = '{4'h6, 4'h6, 4'h5, 4'h5, 4'h8, 4'h8, 4'h8, 4'h8};
    for (int i = 0; i < 8; i++) begin
      add_hdr({2'b00, ty[i]}, 16'h0001, 8'h00);
      burst.push_back(8'hc3);
      go();
      `CHECK("long class", cl[i], 4'(hdr_class))
      `CHECK("long length", 16'h0001, payload_length)
      `CHECK("long done", 1, n_done)
      `CHECK("long bytes", (i == 2 || i == 3) ? 0 : 1, pay_q.size())
      if (pay_q.size() > 0) `CHECK("long byte", 8'hc3, pay_q[0])
    end
    $display("long types done");
  endtask

  // Payload of exactly the length, then a short header in the same burst.
  task automatic t_order();
    add_hdr(8'h39, 16'h0002, 8'h00);
    burst.push_back(8'haa);
    burst.push_back(8'h55);
    add_hdr(8'h05, 16'h0010, 8'h00);
    go();
    `CHECK("order headers", 2, n_hdr)
    `CHECK("order bytes", 2, pay_q.size())
    `CHECK("order first", 8'haa, pay_q[0])
    `CHECK("order type", 6'h05, hdr_type)
    add_hdr(8'h39, 16'h0000, 8'h00);
    add_hdr(8'h09, 16'h0201, 8'h00);
    go();
    `CHECK("empty done", 1, n_done)
    `CHECK("empty headers", 2, n_hdr)
    `CHECK("word order", 16'h0201, payload_length)
    $display("order done");
  endtask

  // Bad code, foreign channel, unknown and disabled generic types.
  task automatic t_refuse();
    logic [7:0] gt [3] = '{8'h11, 8'h12, 8'h1a};
    add_hdr(8'h05, 16'h0010, 8'h01);
    add_hdr(8'h05, 16'h0010, 8'h00);
    go();
    `CHECK("bad code err", 1, n_err)
    `CHECK("bad code hdr", 0, n_hdr)
    add_hdr(8'h45, 16'h0010, 8'h00);
    add_hdr(8'h06, 16'h0011, 8'h00);
    go();
    `CHECK("channel hdr", 1, n_hdr)
    `CHECK("channel type", 6'h06, hdr_type)
    add_hdr(8'h3f, 16'h0010, 8'h00);
    go();
    `CHECK("unknown hdr", 0, n_hdr + n_err)
    @(posedge ref_clk);
    gen_en <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      add_hdr(gt[i], 16'h0010, 8'h00);
      go();
      `CHECK("generic off", 0, n_hdr)
    end
    // A foreign long packet is skipped by length, so the next header still lands.
    add_hdr(8'h79, 16'h0001, 8'h00);
    burst.push_back(8'hc3);
    add_hdr(8'h05, 16'h0010, 8'h00);
    go();
    `CHECK("foreign skip", 0, pay_q.size())
    `CHECK("generic off keep", 1, n_hdr)
    `CHECK("foreign next", 6'h05, hdr_type)
    $display("refusals done");
  endtask

  // Reply headers for each kind, with and without generic types.
  task automatic t_reply();
    logic [5:0] ex [10] = '{6'h02, 6'h21, 6'h22, 6'h1c, 6'h11, 6'h12, 6'h1a,
                           6'h21, 6'h22, 6'h1c};
    logic [1:0]  k;
    logic [15:0] d;
    logic [23:0] h;
    for (int i = 0; i < 10; i++) begin
      k = (i < 4) ? 2'(i) : 2'((i - 4) % 3 + 1);
      d = (k == 2'd1) ? 16'h00a5 : 16'h3ca5;
      h = {d, 2'b00, ex[i]};
      @(posedge ref_clk);
      gen_en <= (i < 7);
      rsp_req <= 1'b1;
      rsp_kind <= pkt_types_pkg::reply_kind_e'(k);
      rsp_generic <= (i >= 4);
      rsp_data <= 16'h3ca5;
      @(posedge ref_clk);
      rsp_req <= 1'b0;
      #1;
      `CHECK("reply valid", 1'b1, rsp_valid)
      `CHECK("reply header", {host.hdr_code(h), h}, rsp_header)
      @(posedge ref_clk);
      #1;
      `CHECK("reply pulse", 1'b0, rsp_valid)
    end
    // A request while the clock enable is low must leave the reply frozen.
    @(posedge ref_clk);
    ce <= 1'b0;
    rsp_req <= 1'b1;
    @(posedge ref_clk);
    ce <= 1'b1;
    rsp_req <= 1'b0;
    #1;
    `CHECK("frozen reply", 1'b0, rsp_valid)
    $display("replies done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    gen_en = 1'b1;
    rsp_req = 1'b0;
    rsp_kind = pkt_types_pkg::rk_ack_error;
    rsp_generic = 1'b0;
    rsp_data = 16'h0000;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_short();
    t_long();
    t_order();
    t_refuse();
    t_reply();
    end_of_test();
  end

  // A hang counts as a failure.
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule
